// *** inv_host_consts.svh ***
// Constants of the inverter-module host controller: offsets, fields, timing.
// Assumes a 250 MHz aclk; included by bare name wherever needed.
`ifndef INV_HOST_CONSTS_SVH
`define INV_HOST_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define HC_ADDR_CTRL 4'h0
`define HC_ADDR_PHASE 4'h4
`define HC_ADDR_STATUS 4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define HC_CTRL_RUN 0
`define HC_CTRL_LOW_DIS 1
`define HC_ST_FAULT_SEEN 0
`define HC_ST_TEMP_SEEN 1
`define HC_ST_FAULT_LVL 2
`define HC_ST_TEMP_LVL 3
`define HC_ST_STATE_LSB 4
`define HC_ST_OUT_LSB 8

// ****************************************************************
// Reset values and bus answers
// ****************************************************************
`define HC_CTRL_RST 2'h0
`define HC_PHASE_RST 6'h00
`define HC_RESP_OKAY 2'h0
`define HC_RESP_SLVERR 2'h2

// ****************************************************************
// Timing: figures in ns, cycle counts rounded up
// ****************************************************************
`define HC_CLK_MHZ 250
`define HC_PW_NS 500
`define HC_DEAD_NS 1500
`define HC_PW_CYC ((`HC_PW_NS * `HC_CLK_MHZ + 999) / 1000)
`define HC_DEAD_CYC ((`HC_DEAD_NS * `HC_CLK_MHZ + 999) / 1000)

`endif

// *** inv_host_pkg.sv ***
// Types of the inverter-module host controller.
// Assumes nothing beyond a SystemVerilog compiler.
package inv_host_pkg;

  // ****************************************************************
  // Sequencing states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, // Outputs commanded off
    ST_RUN = 2'b01, // Outputs follow the phase register
    ST_STOP = 2'b10 // Held off after a temperature limit
  } ctrl_state_t;

endpackage

// *** inv_module_model.sv ***
// Behavioural model of the inverter module seen from its control pins.
// Assumes the host's aclk as a time base and a pulled-up fault/enable line.
`timescale 1ns/1ps

module inv_module_model #(
  parameter int FO_CYC = 5000, // Fault pulse length, cycles
  parameter int RC_CYC = 0, // Stretch from a timing capacitor, cycles
  parameter int OT_TRIP_C = 120 // Strapped trip point, 0 when disabled
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] cmd, // Phase commands {wl,vl,ul,wh,vh,uh}
  input wire logic line, // Resolved fault/enable line level
  input wire logic sc_evt, // Short-circuit event
  input wire logic uv_low, // Common supply below its levels
  input wire logic ot_hot, // Driver above trip point minus hysteresis
  input wire logic hb_low, // High-side bias supply low
  output logic pull_low, // Open-drain pull on the line
  output logic [5:0] gate // Switch states, same order as cmd
);
  // ****************************************************************
  // Fault pulse
  // ****************************************************************
  logic trip; // Any low-side protective stop
  logic ot_act; // Overheat as allowed by the strap
  int fo_ff; // Remaining pulse cycles
  logic [5:0] prev_ff; // Last command levels
  logic [5:0] block_ff; // Switches awaiting a fresh rising input

  assign ot_act = ot_hot && (OT_TRIP_C != 0);
  assign trip = sc_evt | uv_low | ot_act;

  // Pulse restarts while a cause lasts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fo_ff <= 0;
    end else if (trip) begin
      fo_ff <= FO_CYC + RC_CYC;
    end else if (fo_ff != 0) begin
      fo_ff <= fo_ff - 1;
    end
  end

  // Held low for supply and heat, never for high bias
  assign pull_low = (fo_ff != 0) | uv_low | ot_act;

  // ****************************************************************
  // Switch blocking
  // ****************************************************************
  always_ff @(posedge aclk) begin
    prev_ff <= cmd;
  end

  // Low side stops on faults, high side on bias loss only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_ff <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (i >= 3 && (trip || fo_ff != 0)) begin
          block_ff[i] <= 1'b1;
        end else if (i < 3 && hb_low) begin
          block_ff[i] <= 1'b1;
        end else if (cmd[i] && !prev_ff[i]) begin
          block_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Active-high inputs; low line disables the low side
  assign gate = cmd & ~block_ff & {{3{line}}, 3'b111};
endmodule

// *** inverter_host_ctrl.sv ***
// Host controller driving a three-phase inverter module through its pins.
// Assumes AXI4-Lite software access on aclk and asynchronous pin inputs.
//
// Functional notes
// - Driving shared pin low disables low side.
// - Hold every input level at least 0.5us.
// - Leave 1.5us dead time within each leg.
// - Host stops driving above its temperature limit.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`include "inv_host_consts.svh"

module inverter_host_ctrl #(
  parameter int PW_CYC = `HC_PW_CYC, // Least input pulse, cycles
  parameter int DEAD_CYC = `HC_DEAD_CYC // Least dead time, cycles
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic phase_u_high_input,
  output logic phase_v_high_input,
  output logic phase_w_high_input,
  output logic phase_u_low_input,
  output logic phase_v_low_input,
  output logic phase_w_low_input,
  input wire logic fault_enable_pin_i,
  output logic fault_enable_pin_o,
  output logic fault_enable_pin_oe,
  input wire logic temp_over_limit
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  localparam int CW = $clog2(DEAD_CYC + 1); // Switch timer width
  localparam logic [CW-1:0] CNT_MAX = '1; // Timer saturation value
  localparam logic [CW-1:0] PW_C = CW'(PW_CYC);
  localparam logic [CW-1:0] DEAD_C = CW'(DEAD_CYC);

  if (PW_CYC < 1 || DEAD_CYC < PW_CYC) begin : g_bad_timing
    $error("Timing parameters out of range");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  inv_host_pkg::ctrl_state_t state_ff; // Sequencer state
  inv_host_pkg::ctrl_state_t nxt_state;
  logic [1:0] ctrl_ff; // Run and low-side disable
  logic [5:0] phase_ff; // Commanded levels, high side in [2:0]
  logic fault_seen_ff; // Sticky: module signalled a fault
  logic temp_seen_ff; // Sticky: stopped on temperature
  logic fault_meta_ff, fault_sync_ff; // Shared pin synchroniser
  logic temp_meta_ff, temp_sync_ff; // Temperature flag synchroniser
  logic oe_ff, oe_d_ff, oe_d2_ff, pin_lvl_ff; // Shared pin drive
  logic [5:0] sw_ff; // Driven switch levels
  logic [CW-1:0] cnt_ff [6]; // Cycles since each switch changed
  logic [5:0] want; // Switch wants to be on
  logic aw_got_ff, w_got_ff; // Write halves captured
  logic [3:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic do_write; // Both halves in, answer not yet given
  logic wr_ctrl, wr_phase, wr_status;
  logic [3:0] wsel; // Decoded write target
  logic [3:0] rsel; // Decoded read target

  // Maps a byte offset to a register select, bit 3 flags unmapped
  function automatic logic [3:0] reg_sel(input logic [3:0] addr);
    case (addr)
      `HC_ADDR_CTRL: reg_sel = 4'h1;
      `HC_ADDR_PHASE: reg_sel = 4'h2;
      `HC_ADDR_STATUS: reg_sel = 4'h4;
      default: reg_sel = 4'h8;
    endcase
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wsel = reg_sel(awaddr_ff);
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign wr_ctrl = do_write && wsel[0] && wstrb_ff[0];
  assign wr_phase = do_write && wsel[1] && wstrb_ff[0];
  assign wr_status = do_write && wsel[2] && wstrb_ff[0];

  // Address and data taken in either order, answer after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `HC_RESP_OKAY;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (!aw_got_ff && !awready_ff) begin
        awready_ff <= 1'b1; // Open for a new address
      end else if (awready_ff && s_axi_awvalid) begin
        awready_ff <= 1'b0;
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (!w_got_ff && !wready_ff) begin
        wready_ff <= 1'b1; // Open for new data
      end else if (wready_ff && s_axi_wvalid) begin
        wready_ff <= 1'b0;
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wsel[3] ? `HC_RESP_SLVERR : `HC_RESP_OKAY;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0; // Frees both halves for the next write
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  // Target of the address on offer
  assign rsel = reg_sel(s_axi_araddr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `HC_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (rvalid_ff) begin
      if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end else if (!arready_ff) begin
      arready_ff <= 1'b1;
    end else if (s_axi_arvalid) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rsel[3] ? `HC_RESP_SLVERR : `HC_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      case (rsel)
        4'h1: rdata_ff[1:0] <= ctrl_ff;
        4'h2: rdata_ff[5:0] <= phase_ff;
        4'h4: begin
          rdata_ff[`HC_ST_FAULT_SEEN] <= fault_seen_ff;
          rdata_ff[`HC_ST_TEMP_SEEN] <= temp_seen_ff;
          rdata_ff[`HC_ST_FAULT_LVL] <= fault_sync_ff;
          rdata_ff[`HC_ST_TEMP_LVL] <= temp_sync_ff;
          rdata_ff[`HC_ST_STATE_LSB +: 2] <= state_ff;
          rdata_ff[`HC_ST_OUT_LSB +: 6] <= sw_ff;
        end
        default: rdata_ff <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `HC_CTRL_RST;
      phase_ff <= `HC_PHASE_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdata_ff[1:0];
      end
      if (wr_phase) begin
        phase_ff <= wdata_ff[5:0];
      end
    end
  end

  // Sticky flags: a new event wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_seen_ff <= 1'b0;
      temp_seen_ff <= 1'b0;
    end else begin
      if (!fault_sync_ff && !oe_ff && !oe_d_ff && !oe_d2_ff) begin
        fault_seen_ff <= 1'b1;
      end else if (wr_status && wdata_ff[`HC_ST_FAULT_SEEN]) begin
        fault_seen_ff <= 1'b0;
      end
      if (nxt_state == inv_host_pkg::ST_STOP) begin
        temp_seen_ff <= 1'b1;
      end else if (wr_status && wdata_ff[`HC_ST_TEMP_SEEN]) begin
        temp_seen_ff <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pin synchronisers and shared pin drive
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_meta_ff <= 1'b1;
      fault_sync_ff <= 1'b1;
      temp_meta_ff <= 1'b0;
      temp_sync_ff <= 1'b0;
    end else begin
      fault_meta_ff <= fault_enable_pin_i;
      fault_sync_ff <= fault_meta_ff;
      temp_meta_ff <= temp_over_limit;
      temp_sync_ff <= temp_meta_ff;
    end
  end

  // Open-drain: only ever pull low, release lets the pull-up win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_ff <= 1'b0;
      oe_d_ff <= 1'b0;
      oe_d2_ff <= 1'b0;
      pin_lvl_ff <= 1'b0;
    end else begin
      oe_ff <= ctrl_ff[`HC_CTRL_LOW_DIS];
      oe_d_ff <= oe_ff; // Masks own drive while pin recovers
      oe_d2_ff <= oe_d_ff; // Covers both synchroniser stages
      pin_lvl_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      inv_host_pkg::ST_IDLE: begin
        if (ctrl_ff[`HC_CTRL_RUN]) begin
          nxt_state = inv_host_pkg::ST_RUN;
        end
      end
      inv_host_pkg::ST_RUN: begin
        if (temp_sync_ff) begin
          nxt_state = inv_host_pkg::ST_STOP;
        end else if (!ctrl_ff[`HC_CTRL_RUN]) begin
          nxt_state = inv_host_pkg::ST_IDLE;
        end
      end
      inv_host_pkg::ST_STOP: begin
        if (!ctrl_ff[`HC_CTRL_RUN]) begin
          nxt_state = inv_host_pkg::ST_IDLE;
        end
      end
      default: nxt_state = inv_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= inv_host_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Switch timing, one pass per switch
  // ****************************************************************
  for (genvar j = 0; j < 6; j++) begin : g_sw
    localparam int P = (j + 3) % 6; // Other switch of the same leg
    // Off while stopped; low side also off while disabled
    assign want[j] = phase_ff[j] && state_ff == inv_host_pkg::ST_RUN &&
                     !(j >= 3 && oe_ff);

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sw_ff[j] <= 1'b0;
        cnt_ff[j] <= '0;
      end else if (sw_ff[j] && !want[j] && cnt_ff[j] >= PW_C) begin
        sw_ff[j] <= 1'b0;
        cnt_ff[j] <= '0;
      end else if (!sw_ff[j] && want[j] && !want[P] && !sw_ff[P] &&
                   cnt_ff[j] >= PW_C && cnt_ff[P] >= DEAD_C) begin
        sw_ff[j] <= 1'b1;
        cnt_ff[j] <= '0;
      end else if (cnt_ff[j] != CNT_MAX) begin
        cnt_ff[j] <= cnt_ff[j] + 1'b1;
      end
    end

    a_no_shoot_through: assert property (@(posedge aclk)
      disable iff (!aresetn) !(sw_ff[j] && sw_ff[P]))
      else $error("Both switches of a leg on");
    a_dead_time_gap: assert property (@(posedge aclk)
      disable iff (!aresetn) $rose(sw_ff[j]) |-> $past(cnt_ff[P]) >= DEAD_C)
      else $error("Dead time too short");
    a_min_pulse_width: assert property (@(posedge aclk)
      disable iff (!aresetn) $changed(sw_ff[j]) |-> $past(cnt_ff[j]) >= PW_C)
      else $error("Input pulse too short");
    a_active_high_cmd: assert property (@(posedge aclk)
      disable iff (!aresetn) $rose(sw_ff[j]) |-> $past(phase_ff[j]))
      else $error("Switch on without command");
  end

  // ****************************************************************
  // Assertions on sequencing, pin and bus
  // ****************************************************************
  sequence s_temp_trip;
    state_ff == inv_host_pkg::ST_RUN && temp_sync_ff;
  endsequence
  sequence s_all_off;
    sw_ff == 6'h00;
  endsequence

  a_temp_stop_entry: assert property (@(posedge aclk)
    disable iff (!aresetn) s_temp_trip |=> state_ff == inv_host_pkg::ST_STOP
      ##[0:130] s_all_off)
    else $error("Temperature stop not taken");
  a_low_disable_off: assert property (@(posedge aclk)
    disable iff (!aresetn) oe_ff && $past(oe_ff) |-> ##[0:130]
      sw_ff[5:3] == 3'b000)
    else $error("Low side on while disabled");
  a_pin_drive_follow: assert property (@(posedge aclk)
    disable iff (!aresetn) fault_enable_pin_oe ==
      $past(ctrl_ff[`HC_CTRL_LOW_DIS]) && !fault_enable_pin_o)
    else $error("Shared pin drive wrong");
  a_write_answer: assert property (@(posedge aclk)
    disable iff (!aresetn) $rose(bvalid_ff) |-> $past(aw_got_ff && w_got_ff))
    else $error("Write answered early");
  a_read_answer: assert property (@(posedge aclk)
    disable iff (!aresetn) s_axi_arvalid && arready_ff |=> rvalid_ff)
    else $error("Read not answered");

  // ****************************************************************
  // Output wiring, all from flip-flops
  // ****************************************************************
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign phase_u_high_input = sw_ff[0];
  assign phase_v_high_input = sw_ff[1];
  assign phase_w_high_input = sw_ff[2];
  assign phase_u_low_input = sw_ff[3];
  assign phase_v_low_input = sw_ff[4];
  assign phase_w_low_input = sw_ff[5];
  assign fault_enable_pin_o = pin_lvl_ff;
  assign fault_enable_pin_oe = oe_ff;

endmodule

// *** inverter_host_ctrl_tb.sv ***
// Self-checking bench for the inverter host controller.
// Assumes the module model file and the constants header are compiled.
`timescale 1ns/1ps
`include "inv_host_consts.svh"

module inverter_host_ctrl_tb;
  localparam int PW = 4; // Shortened pulse width
  localparam int DEAD = 8; // Shortened dead time
  localparam int FO = 40; // Shortened fault pulse
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, uh, vh, wh, ul, vl, wl;
  logic pin_o, pin_oe, temp_hi, line, pull_low, sc, uv, ot, hb;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, d;
  logic [1:0] bresp, rresp, r;
  logic [5:0] ph, gate, last;
  int errors, tests_run, held[6];

  // ****************************************************************
  // Clock, wiring and instances
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  assign ph = {wl, vl, ul, wh, vh, uh};
  assign line = !((pin_oe && !pin_o) || pull_low); // Pull-up wins only when neither side pulls low

  inverter_host_ctrl #(.PW_CYC(PW), .DEAD_CYC(DEAD)) dut (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_u_high_input(uh), .phase_v_high_input(vh),
    .phase_w_high_input(wh), .phase_u_low_input(ul),
    .phase_v_low_input(vl), .phase_w_low_input(wl),
    .fault_enable_pin_i(line), .fault_enable_pin_o(pin_o),
    .fault_enable_pin_oe(pin_oe), .temp_over_limit(temp_hi));

  inv_module_model #(.FO_CYC(FO)) model (.aclk(aclk), .aresetn(aresetn),
    .cmd(ph), .line(line), .sc_evt(sc), .uv_low(uv), .ot_hot(ot),
    .hb_low(hb), .pull_low(pull_low), .gate(gate));

  // ****************************************************************
  // Compare, verdict and bus tasks
  // ****************************************************************
  task automatic chk_data(input string nm, input logic [31:0] e,
                          input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_resp(input string nm, input logic [1:0] e,
                          input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task give_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Write: offer both channels, release each when taken
  task axi_wr(input logic [3:0] a, input logic [31:0] v,
              output logic [1:0] rsp);
    int n;
    logic aw_ok, w_ok, done;
    aw_ok = 0;
    w_ok = 0;
    done = 0;
    n = 0;
    rsp = 2'h3;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (aw_ok && w_ok && bvalid) begin
        done = 1;
        rsp = bresp;
      end
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b0;
    @(posedge aclk); // One edge before the next request
    if (!done) begin
      errors++;
      give_verdict;
    end
  endtask

  // Read: hold address until taken, then wait for data
  task axi_rd(input logic [3:0] a, output logic [31:0] v,
              output logic [1:0] rsp);
    int n;
    logic ar_ok, done;
    ar_ok = 0;
    done = 0;
    n = 0;
    v = 32'h0000_0000;
    rsp = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 200) begin
      @(posedge aclk);
      n++;
      if (ar_ok && rvalid) begin
        done = 1;
        v = rdata;
        rsp = rresp;
      end
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 1'b0;
      end
    end
    rready <= 1'b0;
    @(posedge aclk); // One edge before the next request
    if (!done) begin
      errors++;
      give_verdict;
    end
  endtask

  task wr_ok(input logic [3:0] a, input logic [31:0] v);
    logic [1:0] rsp;
    axi_wr(a, v, rsp);
    chk_resp("write_resp", `HC_RESP_OKAY, rsp);
  endtask

  task rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0] rsp;
    axi_rd(a, v, rsp);
    chk_data(nm, e, v);
    chk_resp(nm, `HC_RESP_OKAY, rsp);
  endtask

  // Bounded wait for the switch commands
  task wait_ph(input logic [5:0] e);
    int n;
    n = 0;
    while (ph !== e && n < 2000) begin
      @(posedge aclk);
      n++;
    end
    chk_data("outputs", {26'h0, e}, {26'h0, ph});
  endtask

  // ****************************************************************
  // Pulse width and dead time monitor
  // ****************************************************************
  always @(negedge aclk) begin
    if (!aresetn) begin
      last = 6'h00;
      for (int i = 0; i < 6; i++) held[i] = 0;
    end else begin
      for (int i = 0; i < 6; i++) held[i] = held[i] + 1;
      for (int i = 0; i < 6; i++) begin
        if (ph[i] !== last[i]) begin
          chk_data("min_pulse", 32'h0000_0001, {31'h0, held[i] >= PW});
          if (ph[i]) chk_data("dead_time", 32'h0000_0001,
            {31'h0, held[(i + 3) % 6] >= DEAD && !last[(i + 3) % 6]});
          held[i] = 0;
        end
      end
      last = ph;
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    errors = 0;
    tests_run = 0;
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    temp_hi = 1'b0;
    sc = 1'b0;
    uv = 1'b0;
    ot = 1'b0;
    hb = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk("ctrl_rst", `HC_ADDR_CTRL, 32'h0000_0000);
    rd_chk("phase_rst", `HC_ADDR_PHASE, 32'h0000_0000);
    rd_chk("status_rst", `HC_ADDR_STATUS, 32'h0000_0004);
    axi_rd(4'hc, d, r);
    chk_data("unmapped_rd", 32'h0000_0000, d);
    chk_resp("unmapped_rd", `HC_RESP_SLVERR, r);
    axi_wr(4'hc, 32'h0000_0001, r);
    chk_resp("unmapped_wr", `HC_RESP_SLVERR, r);
    wr_ok(`HC_ADDR_PHASE, 32'h0000_0021);
    wr_ok(`HC_ADDR_CTRL, 32'h0000_0001);
    wait_ph(6'h21);
    rd_chk("status_run", `HC_ADDR_STATUS, 32'h0000_2114);
    // Both of a leg wanted: the one already on stays, the other waits
    wr_ok(`HC_ADDR_PHASE, 32'h0000_0009);
    wait_ph(6'h01);
    repeat (3 * DEAD) @(posedge aclk);
    chk_data("leg_conflict", 32'h0000_0001, {26'h0, ph});
    wr_ok(`HC_ADDR_PHASE, 32'h0000_0001);
    wait_ph(6'h01);
    wr_ok(`HC_ADDR_PHASE, 32'h0000_0008);
    wait_ph(6'h08);
    // Short circuit, common supply low, overheat in turn
    for (int k = 0; k < 3; k++) begin
      {ot, uv, sc} <= 3'b001 << k;
      repeat (10) @(posedge aclk);
      {ot, uv, sc} <= 3'b000;
      repeat (FO + 10) @(posedge aclk);
      chk_data("low_gates", 32'h0000_0000, {29'h0, gate[5:3]});
      rd_chk("fault_seen", `HC_ADDR_STATUS, 32'h0000_0815);
      wr_ok(`HC_ADDR_STATUS, 32'h0000_0001);
      rd_chk("fault_clr", `HC_ADDR_STATUS, 32'h0000_0814);
    end
    hb <= 1'b1;
    repeat (20) @(posedge aclk);
    hb <= 1'b0;
    rd_chk("bias_silent", `HC_ADDR_STATUS, 32'h0000_0814);
    wr_ok(`HC_ADDR_CTRL, 32'h0000_0003);
    wait_ph(6'h00);
    rd_chk("low_disable", `HC_ADDR_STATUS, 32'h0000_0010);
    wr_ok(`HC_ADDR_CTRL, 32'h0000_0001);
    wait_ph(6'h08);
    @(posedge aclk);
    chk_data("fresh_edge", 32'h0000_0001, {31'h0, gate[3]});
    temp_hi <= 1'b1;
    wait_ph(6'h00);
    rd_chk("temp_stop", `HC_ADDR_STATUS, 32'h0000_002e);
    temp_hi <= 1'b0;
    wr_ok(`HC_ADDR_CTRL, 32'h0000_0000);
    wr_ok(`HC_ADDR_STATUS, 32'h0000_0002);
    repeat (4) @(posedge aclk);
    rd_chk("idle", `HC_ADDR_STATUS, 32'h0000_0004);
    give_verdict;
  end
endmodule
